//--- core/tsg_pkg.sv
// Purpose: Constants for the touch-shared eight-bit GPIO port
// Assumes: AXI4-Lite register access, 32-bit data, one aligned word per register
// Notes:   Register bits above bit 7 read as zero
package tsg_pkg;

  // ----------------------------------------
  // Bus geometry
  // ----------------------------------------
  localparam int TSG_ADDR_W = 8;
  localparam int TSG_PORT_W = 8;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] TSG_OFS_DATA      = 8'h00;
  localparam logic [7:0] TSG_OFS_DIR       = 8'h04;
  localparam logic [7:0] TSG_OFS_PULLUP    = 8'h08;
  localparam logic [7:0] TSG_OFS_TOUCH_DIS = 8'h0C;
  localparam logic [7:0] TSG_OFS_DATA_RMW  = 8'h10;
  localparam logic [7:0] TSG_OFS_STANDBY   = 8'h14;

  // ----------------------------------------
  // Field layouts
  // ----------------------------------------
  localparam logic [7:0] TSG_PORT_MASK  = 8'hF9;
  localparam logic [7:0] TSG_TOUCH_MASK = 8'hF8;
  localparam int         TSG_SB_FLOAT   = 0;
  localparam int         TSG_SB_TS_RUN  = 1;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] TSG_RST_LATCH     = 8'h00;
  localparam logic [7:0] TSG_RST_DIR       = 8'h00;
  localparam logic [7:0] TSG_RST_PULLUP    = 8'h00;
  localparam logic [7:0] TSG_RST_TOUCH_DIS = 8'h00;
  localparam logic [1:0] TSG_RST_STANDBY   = 2'h0;

  // ----------------------------------------
  // Bus responses
  // ----------------------------------------
  localparam logic [1:0] TSG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TSG_RESP_SLVERR = 2'h2;

endpackage

//--- core/tsg_port.sv
// Purpose: Eight-bit GPIO port shared with peripherals and touch inputs
// Assumes: aclk at 125 MHz, synchronous active-low aresetn, AXI4-Lite slave
// Notes:   Pins are split into input, output and active-low output enable
`timescale 1ns/100ps

// Behaviour
// (R1) Direction bit 1 makes the pin an output driven from its latch bit.
// (R2) Every general-purpose output pin shows the data latch value.
// (R3) Latch writes are stored and forwarded unchanged to output pins.
// (R4) Data reads of general-purpose output pins return the latch, not the pin.
// (R5) Direction bit 0 makes the pin an input.
// (R6) Latch writes on input pins are stored but the pin stays undriven.
// (R7) Input pins: normal reads give pin level, read-modify-write reads give latch.
// (R8) A peripheral output enable drives the pin; normal reads return pin level.
// (R9) Software disables sharing peripheral outputs before general-purpose use.
// (R10) Touch-shared pins: digital input only when touch-disable bit is 1.
// (R11) Reset clears direction and touch-disable bits to 0.
// (R12) Float bit 1 in stop or watch: pins high-impedance, inputs forced low.
// (R13) While floated, pin 0 input stays open if both its interrupt enables are set.
// (R14) Touch stop-run bit 1 keeps touch inputs open in stop or watch.
// (R15) Float bit 0 keeps pin configuration and output levels through standby.
// (R16) Touch use needs direction, touch-disable and pull-up bits cleared by software.
// (R17) Pull-up enable bit 1 connects the internal pull-up.
// (R18) The pull-up disconnects whenever the pin is driven low.
// (R19) Peripheral input use needs direction bit 0; reads return pin level.
// (R20) Only bits 7..3 and 0 exist; bits 2..1 read zero, no touch bit 0.
// (R21) Touch-disable 0 routes to touch input, 1 enables digital input.
module tsg_port
  import tsg_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [TSG_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  input  wire logic [TSG_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  input  wire logic [7:0]            pin_in,
  output logic [7:0]                 pin_out,
  output logic [7:0]                 pin_oe_n,
  output logic [7:0]                 pullup_on,
  input  wire logic [7:0]            periph_oe,
  input  wire logic [7:0]            periph_out,
  output logic [7:0]                 port_in_data,
  output logic [7:0]                 touch_in_en,
  input  wire logic                  standby_mode,
  input  wire logic                  ext_irq_control_ch0,
  input  wire logic                  irq_pin_select_control
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [7:0]            sync1;
    logic [7:0]            sync2;
    logic [7:0]            sync3;
    logic [7:0]            pin_level;
    logic [7:0]            port_data_latch;
    logic [7:0]            port_direction;
    logic [7:0]            port_pullup_enable;
    logic [7:0]            touch_input_disable;
    logic [1:0]            standby_control_reg;
    logic                  aw_held;
    logic [TSG_ADDR_W-1:0] aw_addr;
    logic                  w_held;
    logic [7:0]            w_data;
    logic                  w_lane0;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [7:0]            rdata;
    logic [1:0]            rresp;
  } tsg_state_type;

  tsg_state_type st;
  tsg_state_type next_st;

  logic       standby_pin_float_bit;
  logic       touch_stop_run_enable;
  logic       floated;
  logic [7:0] port_owned;
  logic [7:0] drive_en;
  logic [7:0] drive_val;
  logic [7:0] in_open;
  logic [7:0] normal_read;
  logic       aw_take;
  logic       w_take;
  logic       ar_take;
  logic       wr_fire;

  // ----------------------------------------
  // Pin logic
  // ----------------------------------------
  assign standby_pin_float_bit = st.standby_control_reg[TSG_SB_FLOAT];
  assign touch_stop_run_enable = st.standby_control_reg[TSG_SB_TS_RUN];
  assign floated               = standby_mode & standby_pin_float_bit;                 // R12 R15
  assign port_owned            = st.port_direction & ~periph_oe & TSG_PORT_MASK;        // R1 R5

  generate
    for (genvar i = 0; i < TSG_PORT_W; i++) begin : g_pin
      logic touch_pin;
      logic dig_open;
      assign touch_pin    = TSG_TOUCH_MASK[i];
      assign drive_en[i]  = TSG_PORT_MASK[i] & ~floated
                            & (st.port_direction[i] | periph_oe[i]);                  // R1 R8 R15
      assign drive_val[i] = periph_oe[i] ? periph_out[i] : st.port_data_latch[i];      // R2 R3 R8
      assign pin_out[i]   = drive_en[i] & drive_val[i];                                // R2 R6
      assign pin_oe_n[i]  = ~drive_en[i];                                              // R6 R12
      assign pullup_on[i] = st.port_pullup_enable[i] & ~floated
                            & ~(drive_en[i] & ~drive_val[i]);                          // R17 R18
      assign dig_open     = ~touch_pin | st.touch_input_disable[i];                    // R10 R21
      assign in_open[i]   = TSG_PORT_MASK[i] & dig_open
                            & (~floated | ((i == 0) & ext_irq_control_ch0
                                           & irq_pin_select_control));                 // R12 R13
      assign touch_in_en[i] = touch_pin & ~st.touch_input_disable[i]
                              & (~standby_mode | touch_stop_run_enable);               // R14 R21
    end
  endgenerate

  assign port_in_data = st.pin_level & in_open;                                        // R12
  assign normal_read  = (port_owned & st.port_data_latch)
                        | (~port_owned & port_in_data & TSG_PORT_MASK);                // R4 R7 R8

  // ----------------------------------------
  // Bus handshake
  // ----------------------------------------
  assign s_axi_awready = ~st.aw_held & ~st.bvalid;
  assign s_axi_wready  = ~st.w_held & ~st.bvalid;
  assign s_axi_arready = ~st.rvalid;
  assign s_axi_bvalid  = st.bvalid;
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = {24'h000000, st.rdata};
  assign s_axi_rresp   = st.rresp;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign ar_take       = s_axi_arvalid & s_axi_arready;
  assign wr_fire       = st.aw_held & st.w_held & ~st.bvalid;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] wv;
    wv      = 8'h00;
    next_st = st;
    next_st.sync1 = pin_in;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    // Each pin updates on its own once flops two and three agree
    next_st.pin_level = (st.sync2 & st.sync3) | (st.pin_level & (st.sync2 | st.sync3));
    if (aw_take) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_st.w_held  = 1'b1;
      next_st.w_data  = s_axi_wdata[7:0];
      next_st.w_lane0 = s_axi_wstrb[0];
    end
    if (wr_fire) begin
      wv              = st.w_data;
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = TSG_RESP_OKAY;
      if (st.aw_addr[7:2] == TSG_OFS_DATA[7:2] || st.aw_addr[7:2] == TSG_OFS_DATA_RMW[7:2]) begin
        if (st.w_lane0) begin
          next_st.port_data_latch = wv & TSG_PORT_MASK;                               // R3 R6 R20
        end
      end else if (st.aw_addr[7:2] == TSG_OFS_DIR[7:2]) begin
        if (st.w_lane0) begin
          next_st.port_direction = wv & TSG_PORT_MASK;                                // R1 R5 R20
        end
      end else if (st.aw_addr[7:2] == TSG_OFS_PULLUP[7:2]) begin
        if (st.w_lane0) begin
          next_st.port_pullup_enable = wv & TSG_PORT_MASK;                            // R17 R20
        end
      end else if (st.aw_addr[7:2] == TSG_OFS_TOUCH_DIS[7:2]) begin
        if (st.w_lane0) begin
          next_st.touch_input_disable = wv & TSG_TOUCH_MASK;                          // R10 R20
        end
      end else if (st.aw_addr[7:2] == TSG_OFS_STANDBY[7:2]) begin
        if (st.w_lane0) begin
          next_st.standby_control_reg = wv[1:0];
        end
      end else begin
        next_st.bresp = TSG_RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    if (ar_take) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = TSG_RESP_OKAY;
      if (s_axi_araddr[7:2] == TSG_OFS_DATA[7:2]) begin
        next_st.rdata = normal_read;                                                  // R4 R7 R8
      end else if (s_axi_araddr[7:2] == TSG_OFS_DATA_RMW[7:2]) begin
        next_st.rdata = st.port_data_latch;                                           // R7
      end else if (s_axi_araddr[7:2] == TSG_OFS_DIR[7:2]) begin
        next_st.rdata = st.port_direction;
      end else if (s_axi_araddr[7:2] == TSG_OFS_PULLUP[7:2]) begin
        next_st.rdata = st.port_pullup_enable;
      end else if (s_axi_araddr[7:2] == TSG_OFS_TOUCH_DIS[7:2]) begin
        next_st.rdata = st.touch_input_disable;
      end else if (s_axi_araddr[7:2] == TSG_OFS_STANDBY[7:2]) begin
        next_st.rdata = {6'h00, st.standby_control_reg};
      end else begin
        next_st.rdata = 8'h00;
        next_st.rresp = TSG_RESP_SLVERR;
      end
    end else if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st                     <= '0;
      st.port_data_latch     <= TSG_RST_LATCH;
      st.port_direction      <= TSG_RST_DIR;                                          // R11
      st.port_pullup_enable  <= TSG_RST_PULLUP;
      st.touch_input_disable <= TSG_RST_TOUCH_DIS;                                    // R11
      st.standby_control_reg <= TSG_RST_STANDBY;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_output_follows_latch: assert property ( // R1
    @(posedge aclk) disable iff (!aresetn)
    !floated |-> (((pin_out ^ st.port_data_latch) | pin_oe_n) & port_owned) == 8'h00)
    else $error("output pin does not show latch");

  a_latch_write_stored: assert property ( // R3
    @(posedge aclk) disable iff (!aresetn)
    (wr_fire && st.w_lane0 && st.aw_addr == TSG_OFS_DATA)
    |=> st.port_data_latch == ($past(st.w_data) & TSG_PORT_MASK))
    else $error("latch write not stored");

  a_input_undriven: assert property ( // R6
    @(posedge aclk) disable iff (!aresetn)
    ((~st.port_direction & ~periph_oe & ~pin_oe_n) == 8'h00))
    else $error("input pin is driven");

  a_rmw_read_latch: assert property ( // R7
    @(posedge aclk) disable iff (!aresetn)
    (ar_take && s_axi_araddr == TSG_OFS_DATA_RMW)
    |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(st.port_data_latch))
    else $error("rmw read does not return latch");

  a_reset_clears_cfg: assert property ( // R11
    @(posedge aclk)
    !aresetn |=> st.port_direction == 8'h00 && st.touch_input_disable == 8'h00)
    else $error("reset left direction or touch bits set");

  a_touch_blocks_input: assert property ( // R10
    @(posedge aclk) disable iff (!aresetn)
    !standby_mode |-> ((TSG_TOUCH_MASK & ~st.touch_input_disable)
                       & (port_in_data | ~touch_in_en)) == 8'h00)
    else $error("touch pin digital input not blocked");

  a_float_hiz: assert property ( // R12
    @(posedge aclk) disable iff (!aresetn)
    floated |-> pin_oe_n == 8'hFF
                && (port_in_data & 8'hFE) == 8'h00
                && (port_in_data[0] == 1'b0
                    || (ext_irq_control_ch0 && irq_pin_select_control)))
    else $error("floated pins not high impedance and blocked");

  a_pullup_off_low: assert property ( // R18
    @(posedge aclk) disable iff (!aresetn)
    ((~pin_oe_n & ~pin_out & pullup_on) == 8'h00))
    else $error("pull-up on a pin driven low");

  a_touch_run_stop: assert property ( // R14
    @(posedge aclk) disable iff (!aresetn)
    (standby_mode && touch_stop_run_enable)
    |-> touch_in_en == (TSG_TOUCH_MASK & ~st.touch_input_disable))
    else $error("touch inputs blocked in standby");

  a_unused_bits_zero: assert property ( // R20
    @(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000
                     && (st.port_direction & ~TSG_PORT_MASK) == 8'h00
                     && st.touch_input_disable[0] == 1'b0)
    else $error("unimplemented bits set");

  a_data_read_latch: assert property ( // R4
    @(posedge aclk) disable iff (!aresetn)
    (ar_take && s_axi_araddr == TSG_OFS_DATA)
    |=> (s_axi_rdata[7:0] & $past(port_owned))
        == ($past(st.port_data_latch) & $past(port_owned)))
    else $error("output pin read does not return latch");

  a_input_read_pin: assert property ( // R7 R8
    @(posedge aclk) disable iff (!aresetn)
    (ar_take && s_axi_araddr == TSG_OFS_DATA)
    |=> (s_axi_rdata[7:0] & ~$past(port_owned))
        == ($past(port_in_data) & ~$past(port_owned)))
    else $error("input pin read does not return pin level");

  a_periph_drives_pin: assert property ( // R8
    @(posedge aclk) disable iff (!aresetn)
    !floated |-> (periph_oe & TSG_PORT_MASK & (pin_oe_n | (pin_out ^ periph_out))) == 8'h00)
    else $error("claimed pin not driven by peripheral");

  a_pullup_enabled: assert property ( // R17
    @(posedge aclk) disable iff (!aresetn)
    !floated |-> (st.port_pullup_enable & (pin_oe_n | pin_out) & ~pullup_on) == 8'h00)
    else $error("enabled pull-up not connected");

  a_irq_pin_open: assert property ( // R13
    @(posedge aclk) disable iff (!aresetn)
    (floated && ext_irq_control_ch0 && irq_pin_select_control)
    |-> port_in_data[0] == st.pin_level[0])
    else $error("interrupt pin input blocked while floated");

  a_standby_keeps_pins: assert property ( // R15
    @(posedge aclk) disable iff (!aresetn)
    (standby_mode && !standby_pin_float_bit)
    |-> (port_owned & (pin_oe_n | (pin_out ^ st.port_data_latch))) == 8'h00)
    else $error("pin state changed in standby without float");

  a_digital_input_open: assert property ( // R10 R21
    @(posedge aclk) disable iff (!aresetn)
    !floated |-> (st.touch_input_disable & (port_in_data ^ st.pin_level)) == 8'h00)
    else $error("enabled digital input blocked");

endmodule

//--- tb/tb_touch_shared_gpio_port.sv
// Purpose: Self-checking bench for the touch-shared GPIO port
// Assumes: AXI4-Lite master in the bench, pins resolved by the pin model
// Notes:   Read and write answers are checked against queued expectations
`timescale 1ns/100ps

module tb_touch_shared_gpio_port
  import tsg_pkg::*;
;
  logic aclk = 0, aresetn = 0, standby_mode = 0;
  logic ext_irq_control_ch0 = 0, irq_pin_select_control = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, periph_oe = 0, periph_out = 0;
  logic [7:0] ext_en = 0, ext_val = 0, pin_in, pin_out, pin_oe_n, pullup_on;
  logic [7:0] port_in_data, touch_in_en, r, v;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int num_errors = 0, check_count = 0;

  always #4 aclk = ~aclk;

  tsg_port dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hF),
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .pin_in, .pin_out, .pin_oe_n, .pullup_on, .periph_oe, .periph_out,
    .port_in_data, .touch_in_en, .standby_mode, .ext_irq_control_ch0,
    .irq_pin_select_control);

  tsg_pin_model pins (.aclk, .pin_out, .pin_oe_n, .pullup_on, .ext_en, .ext_val,
    .pin_level(pin_in));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic chk(string n, logic [33:0] e, logic [33:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  always @(negedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) chk("read", rq.pop_front(),
      {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid === 1'b1 && s_axi_bready) chk("bresp", bq.pop_front(), s_axi_bresp);
  end

  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Bus master
  // ----------------------------------------
  task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] rsp = TSG_RESP_OKAY);
    logic aw_ok, w_ok, b_ok;
    @(posedge aclk);
    bq.push_back(rsp);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(negedge aclk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok  = s_axi_wvalid && s_axi_wready;
      b_ok  = s_axi_bvalid && s_axi_bready;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 0;
      if (w_ok) s_axi_wvalid <= 0;
      if (b_ok) break;
    end
    s_axi_bready <= 0;
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e, logic [1:0] rsp = TSG_RESP_OKAY);
    logic ar_ok, r_ok;
    @(posedge aclk);
    rq.push_back({rsp, 24'h0, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok  = s_axi_rvalid && s_axi_rready;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 0;
      if (r_ok) break;
    end
    s_axi_rready <= 0;
  endtask

  task automatic settle();
    repeat (5) @(posedge aclk);
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    report_and_stop();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'hCDD8A61C));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    settle();
    chk("oe_n", 8'hFF, pin_oe_n);
    chk("touch_en", 8'hF8, touch_in_en);
    rd(TSG_OFS_DIR, 8'h00);
    rd(TSG_OFS_TOUCH_DIS, 8'h00);
    r = 8'($urandom);
    wr(TSG_OFS_DATA, r);
    wr(TSG_OFS_DIR, 8'hFF);
    settle();
    chk("pin_out", r & 8'hF9, pin_out);
    chk("oe_n", 8'h06, pin_oe_n);
    rd(TSG_OFS_DATA, r & 8'hF9);
    rd(TSG_OFS_DIR, 8'hF9);
    wr(TSG_OFS_TOUCH_DIS, 8'hFF);
    rd(TSG_OFS_TOUCH_DIS, 8'hF8);
    v = 8'($urandom);
    wr(TSG_OFS_DIR, 8'h00);
    ext_en <= 8'hF9;
    ext_val <= v;
    r = 8'($urandom);
    wr(TSG_OFS_DATA, r);
    settle();
    chk("oe_n", 8'hFF, pin_oe_n);
    rd(TSG_OFS_DATA, v & 8'hF9);
    rd(TSG_OFS_DATA_RMW, r & 8'hF9);
    wr(TSG_OFS_TOUCH_DIS, 8'h00);
    settle();
    chk("in_data", v & 8'h01, port_in_data);
    chk("touch_en", 8'hF8, touch_in_en);
    rd(TSG_OFS_DATA, v & 8'h01);
    ext_en <= 8'hF8;
    periph_oe <= 8'h01;
    periph_out <= 8'h01;
    settle();
    chk("oe_n", 8'hFE, pin_oe_n);
    rd(TSG_OFS_DATA, 8'h01);
    rd(TSG_OFS_DATA_RMW, r & 8'hF9);
    periph_oe <= 8'h00;
    ext_en <= 8'h00;
    wr(TSG_OFS_PULLUP, 8'hFF);
    settle();
    chk("pullup", 8'hF9, pullup_on);
    wr(TSG_OFS_DIR, 8'hFF);
    wr(TSG_OFS_DATA, 8'h0F);
    settle();
    chk("pullup", 8'h09, pullup_on);
    wr(TSG_OFS_STANDBY, 8'h01);
    standby_mode <= 1;
    settle();
    chk("oe_n", 8'hFF, pin_oe_n);
    chk("pullup", 8'h00, pullup_on);
    chk("touch_en", 8'h00, touch_in_en);
    wr(TSG_OFS_DIR, 8'h00);
    ext_en <= 8'h01;
    ext_val <= 8'h01;
    ext_irq_control_ch0 <= 1;
    irq_pin_select_control <= 1;
    settle();
    chk("in_data", 8'h01, port_in_data);
    irq_pin_select_control <= 0;
    settle();
    chk("in_data", 8'h00, port_in_data);
    wr(TSG_OFS_STANDBY, 8'h03);
    settle();
    chk("touch_en", 8'hF8, touch_in_en);
    r = 8'($urandom);
    ext_en <= 8'h00;
    wr(TSG_OFS_STANDBY, 8'h00);
    wr(TSG_OFS_DIR, 8'hFF);
    wr(TSG_OFS_DATA, r);
    settle();
    chk("pin_out", r & 8'hF9, pin_out);
    chk("oe_n", 8'h06, pin_oe_n);
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    settle();
    chk("oe_n", 8'hFF, pin_oe_n);
    rd(TSG_OFS_DIR, 8'h00);
    standby_mode <= 0;
    wr(8'h20, 8'h55, TSG_RESP_SLVERR);
    rd(8'h20, 8'h00, TSG_RESP_SLVERR);
    repeat (4) @(posedge aclk);
    report_and_stop();
  end
endmodule

//--- tb/tsg_pin_model.sv
// Purpose: Pin wires of the eight-bit port as seen from outside the device
// Assumes: The bench drives a pin only while the device leaves it undriven
// Notes:   An undriven pin without pull-up toggles every cycle, it is never stable
`timescale 1ns/100ps

module tsg_pin_model (
  input  wire logic       aclk,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pullup_on,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      pin_level
);
  logic [7:0] flt = 8'hA5;

  always @(posedge aclk) begin
    flt <= ~flt;
  end

  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
      else if (ext_en[i]) pin_level[i] = ext_val[i];
      else if (pullup_on[i]) pin_level[i] = 1'b1;
      else pin_level[i] = flt[i];
    end
  end
endmodule
